/* File: src/ect_consts.svh */
// Register indices, field positions and reset values of the capture/compare timer
`ifndef ECT_CONSTS_SVH
`define ECT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ECT_IDX_CTRL_TWO   7'h3c
`define ECT_IDX_CTRL_ONE   7'h3d
`define ECT_IDX_STATUS     7'h3e
`define ECT_IDX_CAP_ONE    7'h3f
`define ECT_IDX_CMP_ONE    7'h40
`define ECT_IDX_COUNTER    7'h41
`define ECT_IDX_ALT_CNT    7'h42
`define ECT_IDX_CAP_TWO    7'h43
`define ECT_IDX_CMP_TWO    7'h44
`define ECT_ADDR_W         9

// ----------------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------------
`define ECT_C2_CMP1_EN     7
`define ECT_C2_CMP2_EN     6
`define ECT_C2_SINGLE      5
`define ECT_C2_PWM         4
`define ECT_C2_CLK_HI      3
`define ECT_C2_CLK_LO      2
`define ECT_C2_CAP2_EDGE   1

// ----------------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------------
`define ECT_C1_CAP_IE      7
`define ECT_C1_CMP_IE      6
`define ECT_C1_OVF_IE      5
`define ECT_C1_FORCE2      4
`define ECT_C1_FORCE1      3
`define ECT_C1_LEVEL2      2
`define ECT_C1_CAP1_EDGE   1
`define ECT_C1_LEVEL1      0

// ----------------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------------
`define ECT_ST_CAP1        7
`define ECT_ST_CMP1        6
`define ECT_ST_OVF         5
`define ECT_ST_CAP2        4
`define ECT_ST_CMP2        3
`define ECT_ST_DISABLE     2
`define ECT_RST_CTRL       8'h00
`define ECT_RST_CMP        8'h00
`define ECT_RST_COUNTER    8'hfc
`define ECT_CNT_MAX        8'hff

// ----------------------------------------------------------------------
// Prescaler divisors and bus responses
// ----------------------------------------------------------------------
`define ECT_DIV_BY_4       13'd4
`define ECT_DIV_BY_2       13'd2
`define ECT_DIV_BY_8       13'd8
`define ECT_OSC_DIV        8000
`define ECT_RESP_OKAY      2'b00
`define ECT_RESP_SLVERR    2'b10

`endif

/* File: src/ect_pkg.sv */
// Types shared by the capture/compare timer modules
package ect_pkg;
    typedef enum logic [1:0] {
        ECT_CLK_DIV4  = 2'b00,
        ECT_CLK_DIV2  = 2'b01,
        ECT_CLK_DIV8  = 2'b10,
        ECT_CLK_OSC   = 2'b11
    } ect_clk_sel_t;

    typedef enum logic [0:0] {
        ECT_PULSE_IDLE = 1'b0,
        ECT_PULSE_RUN  = 1'b1
    } ect_pulse_t;
endpackage

/* File: src/ect_tick_if.sv */
// Tick request and answer between timer core and prescaler
interface ect_tick_if;
    ect_pkg::ect_clk_sel_t sel;
    logic                  halt;
    logic                  tick;

    modport prescaler (input sel, input halt, output tick);
    modport timer     (output sel, output halt, input tick);
endinterface

/* File: src/ect_prescaler.sv */
// Prescaler producing one-cycle counter ticks from the system clock
`include "ect_consts.svh"

module ect_prescaler #(
    parameter logic [12:0] OSC_DIV = 13'(`ECT_OSC_DIV)
) (
    input  wire logic    aclk,
    input  wire logic    aresetn,
    ect_tick_if.prescaler tk
);

    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    logic [12:0] limit;
    logic        wrap;

    function automatic logic [12:0] div_of(input ect_pkg::ect_clk_sel_t s);
        case (s)
            ect_pkg::ECT_CLK_DIV4: div_of = `ECT_DIV_BY_4;
            ect_pkg::ECT_CLK_DIV2: div_of = `ECT_DIV_BY_2;
            ect_pkg::ECT_CLK_DIV8: div_of = `ECT_DIV_BY_8;
            default:               div_of = OSC_DIV;
        endcase
    endfunction

    assign limit   = div_of(tk.sel);
    assign wrap    = !tk.halt && (cnt_q >= limit - 13'd1);
    assign cnt_d   = tk.halt ? cnt_q : (wrap ? 13'd0 : cnt_q + 13'd1);
    assign tk.tick = wrap;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 13'd0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // ect_prescaler

/* File: src/ect_timer.sv */
// Eight-bit capture/compare timer with AXI4-Lite register access
//
// Operation
// - Pin enable one only routes compare-one output
// - Pin enable two only routes compare-two output
// - Single-pulse mode: capture-one edge fires pulse
// - PWM: compare-one width, compare-two period
// - Clock select picks divide 4, 2, 8, 8000
// - Capture-two edge bit: 0 falling, 1 rising
// - Capture-one flag on capture or PWM period
// - Flags clear by status read, then data access
// - Compare-one flag on counter match outside PWM
// - Compare-two flag on counter match outside PWM
// - Overflow flag on wrap, cleared via counter
// - Alternate counter never clears overflow flag
// - Disable freezes counting and both outputs
// - Capture-one latches counter, read only
// - Capture-two latches counter, read only
// - Compare registers read/write, reset zero
// - Counter resets FCh, writes reset it
// - Interrupt from flags gated by enables
// - Compare-one match drives level one out
// - Both modes set means PWM only
// - Capture-one edge bit: 0 falling, 1 rising
`include "ect_consts.svh"

module ect_timer #(
    parameter logic [12:0] OSC_DIV = 13'(`ECT_OSC_DIV)
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`ECT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output wire logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output wire logic                   s_axi_wready,
    output wire logic [1:0]             s_axi_bresp,
    output wire logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`ECT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output wire logic                   s_axi_arready,
    output wire logic [31:0]            s_axi_rdata,
    output wire logic [1:0]             s_axi_rresp,
    output wire logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   cap1_input_pin,
    input  wire logic                   cap2_input_pin,
    output wire logic                   cmp1_output_pin,
    output wire logic                   cmp1_output_en,
    output wire logic                   cmp2_output_pin,
    output wire logic                   cmp2_output_en,
    output wire logic                   timer_irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [`ECT_ADDR_W-1:0] awaddr_q;
    logic [`ECT_ADDR_W-1:0] rd_addr;
    logic                   aw_held_q;
    logic [31:0]            wdata_q;
    logic                   wlane_q;
    logic                   w_held_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [1:0]             rresp_q;
    logic [31:0]            rdata_q;
    logic [7:0]             ctrl_two_q;
    logic [7:0]             ctrl_one_q;
    logic                   timer_disable_q;
    logic                   cap1_flag_q;
    logic                   cap2_flag_q;
    logic                   cmp1_flag_q;
    logic                   cmp2_flag_q;
    logic                   overflow_flag_q;
    logic [4:0]             arm_q;
    logic [7:0]             capture_one_value_q;
    logic [7:0]             capture_two_value_q;
    logic [7:0]             compare_one_value_q;
    logic [7:0]             compare_two_value_q;
    logic [7:0]             counter_q;
    logic [7:0]             counter_d;
    logic                   cap1_prev_q;
    logic                   cap2_prev_q;
    logic                   out1_q;
    logic                   out1_d;
    logic                   out2_q;
    logic                   out2_d;
    ect_pkg::ect_pulse_t    pulse_q;
    ect_pkg::ect_pulse_t    pulse_d;

    ect_tick_if tk ();

    ect_prescaler #(.OSC_DIV(OSC_DIV)) u_presc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tk      (tk)
    );

    function automatic logic hit(input logic [`ECT_ADDR_W-1:0] a, input logic [6:0] idx);
        hit = (a[`ECT_ADDR_W-1:2] == idx);
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
    wire rd_fire = s_axi_arvalid && !rvalid_q;
    assign rd_addr = s_axi_araddr;

    wire wr_en      = wr_fire && wlane_q;
    wire wr_ctrl2   = wr_en && hit(awaddr_q, `ECT_IDX_CTRL_TWO);
    wire wr_ctrl1   = wr_en && hit(awaddr_q, `ECT_IDX_CTRL_ONE);
    wire wr_status  = wr_en && hit(awaddr_q, `ECT_IDX_STATUS);
    wire wr_cmp1    = wr_en && hit(awaddr_q, `ECT_IDX_CMP_ONE);
    wire wr_cmp2    = wr_en && hit(awaddr_q, `ECT_IDX_CMP_TWO);
    wire wr_cnt     = wr_fire && hit(awaddr_q, `ECT_IDX_COUNTER);
    wire wr_alt     = wr_fire && hit(awaddr_q, `ECT_IDX_ALT_CNT);
    wire wr_mapped  = awaddr_q[`ECT_ADDR_W-1:2] >= `ECT_IDX_CTRL_TWO
                   && awaddr_q[`ECT_ADDR_W-1:2] <= `ECT_IDX_CMP_TWO;
    wire rd_mapped  = rd_addr[`ECT_ADDR_W-1:2] >= `ECT_IDX_CTRL_TWO
                   && rd_addr[`ECT_ADDR_W-1:2] <= `ECT_IDX_CMP_TWO;
    wire rd_status  = rd_fire && hit(rd_addr, `ECT_IDX_STATUS);

    // Accesses of either kind to the data registers
    wire acc_cap1 = (rd_fire && hit(rd_addr, `ECT_IDX_CAP_ONE))
                 || (wr_fire && hit(awaddr_q, `ECT_IDX_CAP_ONE));
    wire acc_cap2 = (rd_fire && hit(rd_addr, `ECT_IDX_CAP_TWO))
                 || (wr_fire && hit(awaddr_q, `ECT_IDX_CAP_TWO));
    wire acc_cmp1 = (rd_fire && hit(rd_addr, `ECT_IDX_CMP_ONE)) || wr_cmp1
                 || (wr_fire && hit(awaddr_q, `ECT_IDX_CMP_ONE));
    wire acc_cmp2 = (rd_fire && hit(rd_addr, `ECT_IDX_CMP_TWO)) || wr_cmp2
                 || (wr_fire && hit(awaddr_q, `ECT_IDX_CMP_TWO));
    wire acc_cnt  = (rd_fire && hit(rd_addr, `ECT_IDX_COUNTER)) || wr_cnt;

    // ------------------------------------------------------------------
    // Modes and events
    // ------------------------------------------------------------------
    wire pwm_on    = ctrl_two_q[`ECT_C2_PWM];
    wire single_on = ctrl_two_q[`ECT_C2_SINGLE] && !pwm_on;
    wire tick      = tk.tick && !timer_disable_q;
    wire [7:0] inc = counter_q + 8'h01;

    wire cap1_edge = ctrl_one_q[`ECT_C1_CAP1_EDGE]
                   ? (cap1_input_pin && !cap1_prev_q)
                   : (!cap1_input_pin && cap1_prev_q);
    wire cap2_edge = ctrl_two_q[`ECT_C2_CAP2_EDGE]
                   ? (cap2_input_pin && !cap2_prev_q)
                   : (!cap2_input_pin && cap2_prev_q);

    wire match1     = tick && (inc == compare_one_value_q);
    wire match2     = tick && (inc == compare_two_value_q);
    wire pwm_period = pwm_on && match2;
    wire trigger    = single_on && cap1_edge && !timer_disable_q;
    wire wrap       = tick && counter_q == `ECT_CNT_MAX && !pwm_period;

    wire set_cap1 = cap1_edge || pwm_period;
    wire set_cap2 = cap2_edge;
    wire set_cmp1 = match1 && !pwm_on;
    wire set_cmp2 = match2 && !pwm_on;

    // ------------------------------------------------------------------
    // Counter and pulse state
    // ------------------------------------------------------------------
    always_comb begin
        counter_d = counter_q;
        pulse_d   = pulse_q;
        if (wr_cnt || wr_alt) begin
            counter_d = `ECT_RST_COUNTER;
        end else if (trigger || pwm_period) begin
            counter_d = `ECT_RST_COUNTER;
        end else if (tick) begin
            counter_d = inc;
        end
        case (pulse_q)
            ect_pkg::ECT_PULSE_IDLE: begin
                if (trigger) begin
                    pulse_d = ect_pkg::ECT_PULSE_RUN;
                end
            end
            ect_pkg::ECT_PULSE_RUN: begin
                if (!single_on || match1) begin
                    pulse_d = ect_pkg::ECT_PULSE_IDLE;
                end
            end
            default: pulse_d = ect_pkg::ECT_PULSE_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Output levels
    // ------------------------------------------------------------------
    wire lvl1 = ctrl_one_q[`ECT_C1_LEVEL1];
    wire lvl2 = ctrl_one_q[`ECT_C1_LEVEL2];

    always_comb begin
        out1_d = out1_q;
        out2_d = out2_q;
        if (!timer_disable_q) begin
            if (pwm_on) begin
                if (pwm_period) begin
                    out1_d = lvl2;
                end else if (match1) begin
                    out1_d = lvl1;
                end
            end else if (single_on) begin
                if (trigger) begin
                    out1_d = lvl2;
                end else if (pulse_q == ect_pkg::ECT_PULSE_RUN && match1) begin
                    out1_d = lvl1;
                end
            end else if (match1 || ctrl_one_q[`ECT_C1_FORCE1]) begin
                out1_d = lvl1;
            end
            if (!pwm_on && (match2 || ctrl_one_q[`ECT_C1_FORCE2])) begin
                out2_d = lvl2;
            end
        end
    end

    assign cmp1_output_en  = ctrl_two_q[`ECT_C2_CMP1_EN] && !timer_disable_q;
    assign cmp2_output_en  = ctrl_two_q[`ECT_C2_CMP2_EN] && !timer_disable_q;
    assign cmp1_output_pin = out1_q;
    assign cmp2_output_pin = out2_q;

    assign tk.halt = timer_disable_q;
    assign tk.sel  = ect_pkg::ect_clk_sel_t'(ctrl_two_q[`ECT_C2_CLK_HI:`ECT_C2_CLK_LO]);

    assign timer_irq = (ctrl_one_q[`ECT_C1_CAP_IE] && (cap1_flag_q || cap2_flag_q))
                    || (ctrl_one_q[`ECT_C1_CMP_IE] && (cmp1_flag_q || cmp2_flag_q))
                    || (ctrl_one_q[`ECT_C1_OVF_IE] && overflow_flag_q);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [7:0] status_byte = {cap1_flag_q, cmp1_flag_q, overflow_flag_q,
                              cap2_flag_q, cmp2_flag_q, timer_disable_q, 2'b00};
    wire [4:0] flag_vec    = {cap1_flag_q, cmp1_flag_q, overflow_flag_q,
                              cap2_flag_q, cmp2_flag_q};
    logic [7:0] rd_byte;

    always_comb begin
        case (rd_addr[`ECT_ADDR_W-1:2])
            `ECT_IDX_CTRL_TWO: rd_byte = {ctrl_two_q[7:1], 1'b0};
            `ECT_IDX_CTRL_ONE: rd_byte = ctrl_one_q;
            `ECT_IDX_STATUS:   rd_byte = status_byte;
            `ECT_IDX_CAP_ONE:  rd_byte = capture_one_value_q;
            `ECT_IDX_CMP_ONE:  rd_byte = compare_one_value_q;
            `ECT_IDX_COUNTER:  rd_byte = counter_q;
            `ECT_IDX_ALT_CNT:  rd_byte = counter_q;
            `ECT_IDX_CAP_TWO:  rd_byte = capture_two_value_q;
            `ECT_IDX_CMP_TWO:  rd_byte = compare_two_value_q;
            default:           rd_byte = 8'h00;
        endcase
    end

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ------------------------------------------------------------------
    // Bus channel registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wlane_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `ECT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wlane_q  <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_mapped ? `ECT_RESP_OKAY : `ECT_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `ECT_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rd_mapped ? `ECT_RESP_OKAY : `ECT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control and data registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_two_q          <= `ECT_RST_CTRL;
            ctrl_one_q          <= `ECT_RST_CTRL;
            timer_disable_q     <= 1'b0;
            compare_one_value_q <= `ECT_RST_CMP;
            compare_two_value_q <= `ECT_RST_CMP;
        end else begin
            if (wr_ctrl2) begin
                ctrl_two_q <= {wdata_q[7:1], 1'b0};
            end
            if (wr_ctrl1) begin
                ctrl_one_q <= wdata_q[7:0];
            end
            if (wr_status) begin
                timer_disable_q <= wdata_q[`ECT_ST_DISABLE];
            end
            if (wr_cmp1) begin
                compare_one_value_q <= wdata_q[7:0];
            end
            if (wr_cmp2) begin
                compare_two_value_q <= wdata_q[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_q           <= `ECT_RST_COUNTER;
            pulse_q             <= ect_pkg::ECT_PULSE_IDLE;
            out1_q              <= 1'b0;
            out2_q              <= 1'b0;
            cap1_prev_q         <= 1'b0;
            cap2_prev_q         <= 1'b0;
            capture_one_value_q <= 8'h00;
            capture_two_value_q <= 8'h00;
        end else begin
            counter_q   <= counter_d;
            pulse_q     <= pulse_d;
            out1_q      <= out1_d;
            out2_q      <= out2_d;
            cap1_prev_q <= cap1_input_pin;
            cap2_prev_q <= cap2_input_pin;
            if (cap1_edge) begin
                capture_one_value_q <= counter_q;
            end
            if (cap2_edge) begin
                capture_two_value_q <= counter_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags: a set wins over a clear in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap1_flag_q     <= 1'b0;
            cmp1_flag_q     <= 1'b0;
            overflow_flag_q <= 1'b0;
            cap2_flag_q     <= 1'b0;
            cmp2_flag_q     <= 1'b0;
            arm_q           <= 5'b00000;
        end else begin
            cap1_flag_q     <= set_cap1 || (cap1_flag_q && !(arm_q[4] && acc_cap1));
            cmp1_flag_q     <= set_cmp1 || (cmp1_flag_q && !(arm_q[3] && acc_cmp1));
            overflow_flag_q <= wrap || (overflow_flag_q && !(arm_q[2] && acc_cnt));
            cap2_flag_q     <= set_cap2 || (cap2_flag_q && !(arm_q[1] && acc_cap2));
            cmp2_flag_q     <= set_cmp2 || (cmp2_flag_q && !(arm_q[0] && acc_cmp2));
            if (rd_status) begin
                arm_q <= flag_vec;
            end else begin
                arm_q <= arm_q & ~{acc_cap1, acc_cmp1, acc_cnt, acc_cap2, acc_cmp2};
            end
        end
    end

endmodule // ect_timer

/* File: verif/ect_timer_assertions.sv */
// Port-level assertions of the capture/compare timer
module ect_timer_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [8:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        cmp1_output_en,
    input wire logic        cmp2_output_en,
    input wire logic        timer_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] ra_q;
    wire        rd_c2 = s_axi_rvalid && ra_q == 9'h0f0;
    wire        rd_c1 = s_axi_rvalid && ra_q == 9'h0f4;
    wire        rd_st = s_axi_rvalid && ra_q == 9'h0f8;
    wire        bad   = ra_q[8:2] < 7'h3c || ra_q[8:2] > 7'h44;
    // Address of the read under way
    always_ff @(posedge aclk) begin
        if (!aresetn) ra_q <= 9'h000;
        else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    rsv_bit_a: assert property (rd_c2 |-> !s_axi_rdata[0])
        else $error("reserved bit set");
    dis_gate_a: assert property (rd_st && s_axi_rdata[2] |-> !cmp1_output_en)
        else $error("output on while disabled");
    pin_one_a: assert property (rd_c2 && !s_axi_rdata[7] |-> !cmp1_output_en)
        else $error("pin one enabled");
    pin_two_a: assert property (rd_c2 && !s_axi_rdata[6] |-> !cmp2_output_en)
        else $error("pin two enabled");
    irq_mask_a: assert property (rd_c1 && s_axi_rdata[7:5] == 3'h0 |-> !timer_irq)
        else $error("irq while masked");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    bad_addr_a: assert property (s_axi_rvalid && bad |-> s_axi_rresp == 2'h2)
        else $error("no slave error");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read answer");
    cover property (s_axi_rvalid && bad);
    cover property (timer_irq);
    cover property ($rose(cmp1_output_en));
endmodule // ect_timer_assertions

/* File: verif/ect_pin_model.sv */
// Far-side model driving the capture input pins
module ect_pin_model (
    input  wire logic aclk,
    output logic      cap1_input_pin,
    output logic      cap2_input_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial cap1_input_pin = 1'b0;
    initial cap2_input_pin = 1'b0;
    // Both pins move together; edge select decides which captures
    task automatic drive(input logic lv);
        @(posedge aclk);
        cap1_input_pin <= lv;
        cap2_input_pin <= lv;
        repeat (2) @(posedge aclk);
    endtask
endmodule // ect_pin_model

/* File: verif/ect_timer_tb.sv */
// Register-level testbench of the capture/compare timer
module ect_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [8:0]  s_axi_awaddr = 9'h000, s_axi_araddr = 9'h000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        cap1_input_pin, cap2_input_pin, cmp1_output_pin, cmp2_output_pin;
    logic        cmp1_output_en, cmp2_output_en, timer_irq;
    int          n_fail = 0, samples_checked = 0;
    always #12.5 aclk = ~aclk;
    ect_timer #(.OSC_DIV(13'h10)) i_ect_timer (.*);
    ect_pin_model i_ect_pin_model (
        .aclk           (aclk),
        .cap1_input_pin (cap1_input_pin),
        .cap2_input_pin (cap2_input_pin)
    );
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({6'h0, s_axi_bresp}, 8'h00);
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata[7:0], e);
    endtask
    task automatic tally_and_finish();
        $display("Checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(9'h0f8, 8'h04);
        rd(9'h0f8, 8'h04);
        rd(9'h0f0, 8'h00);
        rd(9'h100, 8'h00);
        rd(9'h110, 8'h00);
        wr(9'h0f0, 8'hc4);
        rd(9'h0f0, 8'hc4);
        chk({6'h0, cmp1_output_en, cmp2_output_en}, 8'h00);
        wr(9'h104, 8'h55);
        rd(9'h104, 8'hfc);
        rd(9'h108, 8'hfc);
        wr(9'h0fc, 8'h33);
        rd(9'h0fc, 8'h00);
        wr(9'h100, 8'hfe);
        wr(9'h110, 8'hfd);
        wr(9'h0f4, 8'h05);
        wr(9'h0f8, 8'h00);
        chk({6'h0, cmp1_output_en, cmp2_output_en}, 8'h03);
        repeat (40) @(posedge aclk);
        chk({6'h0, cmp1_output_pin, cmp2_output_pin}, 8'h03);
        wr(9'h0f8, 8'h04);
        rd(9'h0f8, 8'h6c);
        wr(9'h0f4, 8'h40);
        chk({7'h0, timer_irq}, 8'h01);
        wr(9'h0f4, 8'h00);
        rd(9'h0f4, 8'h00);
        wr(9'h108, 8'h00);
        rd(9'h0f8, 8'h6c);
        rd(9'h104, 8'hfc);
        rd(9'h0f8, 8'h4c);
        rd(9'h100, 8'hfe);
        rd(9'h0f8, 8'h0c);
        wr(9'h110, 8'hfd);
        rd(9'h0f8, 8'h04);
        rd(9'h1f0, 8'h00);
        wr(9'h0f4, 8'h02);
        i_ect_pin_model.drive(1'b1);
        rd(9'h0f8, 8'h84);
        i_ect_pin_model.drive(1'b0);
        rd(9'h0f8, 8'h94);
        rd(9'h0fc, 8'hfc);
        rd(9'h10c, 8'hfc);
        // PWM with single-pulse bit also set
        wr(9'h0f0, 8'hf4);
        wr(9'h0f8, 8'h00);
        repeat (8) @(posedge aclk);
        wr(9'h0f8, 8'h04);
        rd(9'h0f8, 8'h84);
        chk({7'h0, cmp1_output_pin}, 8'h00);
        // Single pulse on a rising capture-one edge
        wr(9'h0f0, 8'ha4);
        wr(9'h0f4, 8'h06);
        wr(9'h0f8, 8'h00);
        i_ect_pin_model.drive(1'b1);
        chk({7'h0, cmp1_output_pin}, 8'h01);
        repeat (8) @(posedge aclk);
        chk({7'h0, cmp1_output_pin}, 8'h00);
        tally_and_finish();
    end
    initial begin
        #40000;
        n_fail++;
        tally_and_finish();
    end
endmodule // ect_timer_tb
bind ect_timer ect_timer_assertions i_ect_timer_assertions (.*);
